// ===== dpw_cfg.svh
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH

// ----------------------------------------
// Register indices, byte address is 4 x index
// ----------------------------------------
`define DPW_IDX_CTRL_ONE   12'h001
`define DPW_IDX_CTRL_TWO   12'h002
`define DPW_IDX_RUN_CTRL   12'h003
`define DPW_IDX_DT1_LO     12'h008
`define DPW_IDX_DT1_HI     12'h009
`define DPW_IDX_PW1_LO     12'h00A
`define DPW_IDX_PW1_HI     12'h00B
`define DPW_IDX_PER_LO     12'h00C
`define DPW_IDX_PER_HI     12'h00D
`define DPW_IDX_DT2_LO     12'hFB0
`define DPW_IDX_DT2_HI     12'hFB1
`define DPW_IDX_PW2_LO     12'hFB2
`define DPW_IDX_PW2_HI     12'hFB3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPW_ONE_SHOT_BIT   0
`define DPW_MODE_LSB       0
`define DPW_START_BIT      0
`define DPW_BUSY_BIT       1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define DPW_DATA_RST       10'h000
`define DPW_MODE_RST       2'h0
`define DPW_FULL_COUNT     11'h400

`endif

// ===== dpw_pkg.sv
package dpw_pkg;

    typedef enum logic [1:0] {
        DPW_MODE_INDEP = 2'h0,
        DPW_MODE_RSVD  = 2'h1,
        DPW_MODE_VAR   = 2'h2,
        DPW_MODE_HALF  = 2'h3
    } dpw_mode_t;

    typedef enum logic [1:0] {
        DPW_ST_IDLE = 2'b01,
        DPW_ST_RUN  = 2'b10
    } dpw_state_t;

    typedef struct packed {
        logic [9:0] dt1;
        logic [9:0] pw1;
        logic [9:0] per;
        logic [9:0] dt2;
        logic [9:0] pw2;
    } dpw_hold_t;

    typedef struct packed {
        logic [10:0] per;
        logic [10:0] on1;
        logic [10:0] off1;
        logic [10:0] on2;
        logic [10:0] off2;
    } dpw_cmp_t;

endpackage

// ===== dpw_waveform_gen.sv
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "dpw_cfg.svh"
module dpw_waveform_gen (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pulse outputs and timer events
    output logic             pulse_out_one,
    output logic             pulse_out_two,
    output logic             period_match,
    output logic             counter_clear
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // A zero in a ten-bit width or period stands for the full 400H count
    function automatic logic [10:0] to_count(input logic [9:0] v);
        to_count = (v == 10'h000) ? `DPW_FULL_COUNT : {1'b0, v};
    endfunction

    function automatic logic in_window(input logic [10:0] cnt, input logic [10:0] on, input logic [10:0] off);
        in_window = (cnt >= on) && (cnt < off);
    endfunction

    function automatic logic [9:0] byte_write(input logic [9:0] old, input logic lo, input logic hi,
                                              input logic [7:0] d);
        logic [9:0] v;
        v = old;
        if (lo) begin
            v[7:0] = d;
        end
        if (hi) begin
            v[9:8] = d[1:0];
        end
        byte_write = v;
    endfunction

    function automatic logic [31:0] byte_read(input logic [9:0] v, input logic hi);
        byte_read = hi ? {30'h0, v[9:8]} : {24'h0, v[7:0]};
    endfunction

    // Mode-specific processing of staged values into compare points
    function automatic dpw_pkg::dpw_cmp_t cmp_points(input dpw_pkg::dpw_mode_t m, input dpw_pkg::dpw_hold_t h,
                                                     input dpw_pkg::dpw_cmp_t old);
        dpw_pkg::dpw_cmp_t c;
        logic [10:0]       per;
        logic [10:0]       half;
        logic [10:0]       w1;
        c    = old;
        per  = to_count(h.per);
        half = {1'b0, per[10:1]};
        w1   = to_count(h.pw1);
        c.per = per;
        unique case (m)
            dpw_pkg::DPW_MODE_HALF: begin
                c.on1  = {1'b0, h.dt1};
                c.off1 = half;
                c.on2  = half + {1'b0, h.dt1};
                c.off2 = per;
            end
            dpw_pkg::DPW_MODE_VAR: begin
                c.on1  = {1'b0, h.dt1};
                c.off1 = w1;
                c.on2  = w1 + {1'b0, h.dt1};
                c.off2 = per;
            end
            dpw_pkg::DPW_MODE_INDEP, dpw_pkg::DPW_MODE_RSVD: begin
                c.on1  = {1'b0, h.dt1};
                c.off1 = w1;
                c.on2  = {1'b0, h.dt2};
                c.off2 = to_count(h.pw2);
            end
        endcase
        cmp_points = c;
    endfunction

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic                 one_shot_ff;
    dpw_pkg::dpw_mode_t   mode_ff;
    logic                 start_bit_ff;
    dpw_pkg::dpw_hold_t   hold_ff;
    dpw_pkg::dpw_hold_t   nxt_hold;
    dpw_pkg::dpw_hold_t   snap_ff;
    dpw_pkg::dpw_cmp_t    cmp_ff;
    logic                 pending_ff;
    logic                 dirty_ff;
    dpw_pkg::dpw_state_t  state_ff;
    logic [9:0]           cnt_ff;
    logic [31:0]          prdata_ff;
    logic                 out_one_ff;
    logic                 out_two_ff;
    logic                 match_ff;
    logic                 clear_ff;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic [11:0] idx;
    logic        wr;
    logic        mapped;
    logic        data_wr;
    logic        per_hi_wr;
    logic        run_wr;
    logic        running;
    logic        match;
    logic        boundary;
    logic [31:0] rd_mux;

    assign idx = paddr[13:2];
    assign wr  = psel && penable && pwrite && mapped;

    always_comb begin
        unique case (idx)
            `DPW_IDX_CTRL_ONE, `DPW_IDX_CTRL_TWO, `DPW_IDX_RUN_CTRL,
            `DPW_IDX_DT1_LO, `DPW_IDX_DT1_HI, `DPW_IDX_PW1_LO, `DPW_IDX_PW1_HI,
            `DPW_IDX_PER_LO, `DPW_IDX_PER_HI, `DPW_IDX_DT2_LO, `DPW_IDX_DT2_HI,
            `DPW_IDX_PW2_LO, `DPW_IDX_PW2_HI: mapped = 1'b1;
            default:                          mapped = 1'b0;
        endcase
    end

    // Zero wait states; unmapped words answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    assign per_hi_wr = wr && (idx == `DPW_IDX_PER_HI);
    assign run_wr    = wr && (idx == `DPW_IDX_RUN_CTRL);
    assign data_wr   = wr && (idx[11:3] == 9'h001 || idx[11:2] == 10'h3EC);

    always_comb begin
        nxt_hold     = hold_ff;
        nxt_hold.dt1 = byte_write(hold_ff.dt1, wr && idx == `DPW_IDX_DT1_LO, wr && idx == `DPW_IDX_DT1_HI,
                                  pwdata[7:0]);
        nxt_hold.pw1 = byte_write(hold_ff.pw1, wr && idx == `DPW_IDX_PW1_LO, wr && idx == `DPW_IDX_PW1_HI,
                                  pwdata[7:0]);
        nxt_hold.per = byte_write(hold_ff.per, wr && idx == `DPW_IDX_PER_LO, per_hi_wr, pwdata[7:0]);
        nxt_hold.dt2 = byte_write(hold_ff.dt2, wr && idx == `DPW_IDX_DT2_LO, wr && idx == `DPW_IDX_DT2_HI,
                                  pwdata[7:0]);
        nxt_hold.pw2 = byte_write(hold_ff.pw2, wr && idx == `DPW_IDX_PW2_LO, wr && idx == `DPW_IDX_PW2_HI,
                                  pwdata[7:0]);
    end

    always_comb begin
        unique case (idx)
            `DPW_IDX_CTRL_ONE: rd_mux = {31'h0, one_shot_ff};
            `DPW_IDX_CTRL_TWO: rd_mux = {30'h0, mode_ff};
            `DPW_IDX_RUN_CTRL: rd_mux = {30'h0, running, start_bit_ff};
            `DPW_IDX_DT1_LO:   rd_mux = byte_read(hold_ff.dt1, 1'b0);
            `DPW_IDX_DT1_HI:   rd_mux = byte_read(hold_ff.dt1, 1'b1);
            `DPW_IDX_PW1_LO:   rd_mux = byte_read(hold_ff.pw1, 1'b0);
            `DPW_IDX_PW1_HI:   rd_mux = byte_read(hold_ff.pw1, 1'b1);
            `DPW_IDX_PER_LO:   rd_mux = byte_read(hold_ff.per, 1'b0);
            `DPW_IDX_PER_HI:   rd_mux = byte_read(hold_ff.per, 1'b1);
            `DPW_IDX_DT2_LO:   rd_mux = byte_read(hold_ff.dt2, 1'b0);
            `DPW_IDX_DT2_HI:   rd_mux = byte_read(hold_ff.dt2, 1'b1);
            `DPW_IDX_PW2_LO:   rd_mux = byte_read(hold_ff.pw2, 1'b0);
            `DPW_IDX_PW2_HI:   rd_mux = byte_read(hold_ff.pw2, 1'b1);
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data sampled in the setup cycle, stable through the access phase
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end
    assign prdata = prdata_ff;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            one_shot_ff  <= 1'b0;
            mode_ff      <= dpw_pkg::DPW_MODE_INDEP;
            start_bit_ff <= 1'b0;
        end else begin
            if (wr && idx == `DPW_IDX_CTRL_ONE) begin
                one_shot_ff <= pwdata[`DPW_ONE_SHOT_BIT];
            end
            if (wr && idx == `DPW_IDX_CTRL_TWO) begin
                mode_ff <= dpw_pkg::dpw_mode_t'(pwdata[`DPW_MODE_LSB +: 2]);
            end
            if (run_wr) begin
                start_bit_ff <= pwdata[`DPW_START_BIT];
            end
        end
    end

    // ----------------------------------------
    // Holding registers and transfer staging
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hold_ff <= {5{`DPW_DATA_RST}};
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    // Staged copy taken at the period upper-byte write; a rewrite after it
    // rides one more boundary so the last values follow a period later
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            snap_ff    <= {5{`DPW_DATA_RST}};
            pending_ff <= 1'b0;
            dirty_ff   <= 1'b0;
        end else if (per_hi_wr) begin
            snap_ff    <= nxt_hold;
            pending_ff <= 1'b1;
            dirty_ff   <= 1'b0;
        end else if (boundary && pending_ff) begin
            if (dirty_ff || data_wr) begin
                snap_ff    <= nxt_hold;
                pending_ff <= 1'b1;
            end else begin
                pending_ff <= 1'b0;
            end
            dirty_ff <= 1'b0;
        end else if (data_wr && pending_ff) begin
            dirty_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_ff <= '{per: `DPW_FULL_COUNT, default: 11'h000};
        end else if (boundary && pending_ff) begin
            cmp_ff <= cmp_points(mode_ff, snap_ff, cmp_ff);
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    assign running  = (state_ff == dpw_pkg::DPW_ST_RUN);
    assign match    = running && ({1'b0, cnt_ff} == cmp_ff.per - 11'h001);
    assign boundary = match || (run_wr && pwdata[`DPW_START_BIT]);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= dpw_pkg::DPW_ST_IDLE;
            cnt_ff   <= 10'h000;
        end else if (run_wr) begin
            // A start write always restarts from a cleared count
            state_ff <= pwdata[`DPW_START_BIT] ? dpw_pkg::DPW_ST_RUN : dpw_pkg::DPW_ST_IDLE;
            cnt_ff   <= 10'h000;
        end else begin
            unique case (state_ff)
                dpw_pkg::DPW_ST_IDLE: begin
                    cnt_ff <= 10'h000;
                end
                dpw_pkg::DPW_ST_RUN: begin
                    if (match) begin
                        cnt_ff <= 10'h000;
                        if (one_shot_ff) begin
                            state_ff <= dpw_pkg::DPW_ST_IDLE;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 10'h001;
                    end
                end
                default: begin
                    state_ff <= dpw_pkg::DPW_ST_IDLE;
                    cnt_ff   <= 10'h000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Pulse outputs
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            out_one_ff <= 1'b0;
            out_two_ff <= 1'b0;
        end else begin
            out_one_ff <= running && in_window({1'b0, cnt_ff}, cmp_ff.on1, cmp_ff.off1);
            out_two_ff <= running && in_window({1'b0, cnt_ff}, cmp_ff.on2, cmp_ff.off2);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            match_ff <= 1'b0;
            clear_ff <= 1'b0;
        end else begin
            match_ff <= match;
            clear_ff <= boundary || run_wr;
        end
    end

    assign pulse_out_one = out_one_ff;
    assign pulse_out_two = out_two_ff;
    assign period_match  = match_ff;
    assign counter_clear = clear_ff;

endmodule

// ===== dpw_checker.sv
`timescale 1ns/1ns
`include "dpw_cfg.svh"
module dpw_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Outputs
    input wire logic        pulse_out_one,
    input wire logic        pulse_out_two,
    input wire logic        period_match,
    input wire logic        counter_clear
);
    logic        mode_dual_ff;
    logic        run_ff;
    logic        run_q_ff;
    logic [11:0] idx;
    logic        acc;
    logic        is_data;
    logic        mapped;
    assign idx = paddr[13:2];
    assign acc = psel && penable;
    assign is_data = (idx >= `DPW_IDX_DT1_LO && idx <= `DPW_IDX_PER_HI) ||
                     (idx >= `DPW_IDX_DT2_LO && idx <= `DPW_IDX_PW2_HI);
    assign mapped = is_data || (idx >= `DPW_IDX_CTRL_ONE && idx <= `DPW_IDX_RUN_CTRL);
    // ----------------------------------------
    // Bus mirror, only the port view is known
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_dual_ff <= 1'b0;
        end else if (acc && pwrite && idx == `DPW_IDX_CTRL_TWO) begin
            mode_dual_ff <= pwdata[1];
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            run_ff <= 1'b0;
        end else if (acc && pwrite && idx == `DPW_IDX_RUN_CTRL) begin
            run_ff <= pwdata[0];
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            run_q_ff <= 1'b0;
        end else begin
            run_q_ff <= run_ff;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    AST_PREADY: assert property (acc |-> pready)
        else $error("pready low in access phase");
    AST_SLVERR_IDLE: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access phase");
    AST_SLVERR_MAP: assert property (acc |-> (pslverr == !mapped))
        else $error("pslverr does not match address map");
    AST_UNMAP_RD: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    AST_RD_UPPER: assert property (acc && !pwrite && is_data && idx[0] |-> prdata[31:2] == 30'h0)
        else $error("upper byte read has stray bits");
    AST_RUN_CLEAR: assert property (acc && pwrite && idx == `DPW_IDX_RUN_CTRL |=> counter_clear)
        else $error("no counter clear after run write");
    AST_PM_SINGLE: assert property (period_match |=> !period_match)
        else $error("period match longer than one cycle");
    AST_EXCL: assert property (mode_dual_ff |-> !(pulse_out_one && pulse_out_two))
        else $error("both outputs active in a complementary mode");
    AST_STOPPED: assert property (!run_ff && !run_q_ff |-> !pulse_out_one && !pulse_out_two)
        else $error("output active while stopped");
endmodule
bind dpw_waveform_gen dpw_checker u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_out_one(pulse_out_one), .pulse_out_two(pulse_out_two), .period_match(period_match),
    .counter_clear(counter_clear));

// ===== dpw_testbench.sv
`timescale 1ns/1ns
`include "dpw_cfg.svh"
module testbench;
    logic        mclk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pulse_out_one;
    logic        pulse_out_two;
    logic        period_match;
    logic        counter_clear;
    logic [31:0] rd;
    logic        er;
    int          miscompares;
    int          checks;
    dpw_waveform_gen u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_out_one(pulse_out_one), .pulse_out_two(pulse_out_two),
        .period_match(period_match), .counter_clear(counter_clear));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rdv = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            miscompares++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, rd, er);
    endtask
    task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, rd, er);
        chk(rd, exp, "register read");
    endtask
    // Low byte first, upper bits follow
    task automatic set16(input logic [11:0] lo, input logic [10:0] v);
        wr(lo, {24'h0, v[7:0]});
        wr(lo + 12'h001, {30'h0, v[9:8]});
    endtask
    // Stop before touching the mode, period upper byte last before the start write
    task automatic cfg(input logic [1:0] md, input logic [10:0] d1, w1, p, d2, w2);
        wr(`DPW_IDX_RUN_CTRL, 32'h0);
        wr(`DPW_IDX_CTRL_TWO, {30'h0, md});
        set16(`DPW_IDX_DT1_LO, d1);
        set16(`DPW_IDX_PW1_LO, w1);
        set16(`DPW_IDX_DT2_LO, d2);
        set16(`DPW_IDX_PW2_LO, w2);
        set16(`DPW_IDX_PER_LO, p);
        wr(`DPW_IDX_RUN_CTRL, 32'h1);
    endtask
    // Counts from the next edge with no boundary wait; measure waits for two matches first
    task automatic count_active(input int cyc, input int e1, input int e2);
        int c1;
        int c2;
        c1 = 0;
        c2 = 0;
        repeat (cyc) begin
            @(posedge mclk);
            #1;
            if (pulse_out_one === 1'b1) c1++;
            if (pulse_out_two === 1'b1) c2++;
        end
        chk(c1, e1, "pulse one active count");
        chk(c2, e2, "pulse two active count");
    endtask
    task automatic measure(input int per, input int e1, input int e2);
        int hits;
        int t1;
        int n;
        hits = 0;
        t1 = 0;
        n = 0;
        while (hits < 2 && n < 5000) begin
            @(posedge mclk);
            #1;
            n++;
            if (period_match === 1'b1) begin
                hits++;
                if (hits == 1) begin
                    t1 = n;
                end else begin
                    chk(n - t1, per, "period match spacing");
                end
            end
        end
        // A missing match is a failure, not a silent skip
        chk(hits, 2, "period matches seen");
        count_active(per, e1, e2);
    endtask
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        report_and_stop;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        miscompares = 0;
        checks = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        rchk(`DPW_IDX_PER_LO, 32'h0);
        rchk(`DPW_IDX_DT2_HI, 32'h0);
        wr(`DPW_IDX_PW1_HI, 32'hFF);
        rchk(`DPW_IDX_PW1_HI, 32'h3);
        set16(`DPW_IDX_PER_LO, 11'h400);
        rchk(`DPW_IDX_PER_LO, 32'h0);
        rchk(`DPW_IDX_PER_HI, 32'h0);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped error flag");
        chk(rd, 32'h0, "unmapped read data");
        cfg(dpw_pkg::DPW_MODE_HALF, 11'h000, 11'h003, 11'h005, 11'h000, 11'h000);
        measure(5, 5 / 2, 5 - 5 / 2);
        cfg(dpw_pkg::DPW_MODE_HALF, 11'h001, 11'h000, 11'h005, 11'h000, 11'h000);
        measure(5, 5 / 2 - 1, 5 - 5 / 2 - 1);
        cfg(dpw_pkg::DPW_MODE_VAR, 11'h001, 11'h003, 11'h008, 11'h000, 11'h000);
        measure(8, 3 - 1, 8 - 3 - 1);
        cfg(dpw_pkg::DPW_MODE_INDEP, 11'h001, 11'h004, 11'h006, 11'h002, 11'h005);
        measure(6, 4 - 1, 5 - 2);
        cfg(dpw_pkg::DPW_MODE_INDEP, 11'h000, 11'h006, 11'h006, 11'h006, 11'h006);
        measure(6, 6, 0);
        set16(`DPW_IDX_PW1_LO, 11'h002);
        measure(6, 6, 0);
        wr(`DPW_IDX_PER_HI, 32'h0);
        measure(6, 2, 0);
        set16(`DPW_IDX_PW1_LO, 11'h004);
        wr(`DPW_IDX_PER_HI, 32'h0);
        set16(`DPW_IDX_PW1_LO, 11'h003);
        measure(6, 3, 0);
        rchk(`DPW_IDX_RUN_CTRL, 32'h3);
        wr(`DPW_IDX_RUN_CTRL, 32'h0);
        #1;
        chk({31'h0, counter_clear}, 32'h1, "counter clear after stop write");
        // Outputs lag the counter by one cycle, skip the last running one
        @(posedge mclk);
        count_active(5, 0, 0);
        wr(`DPW_IDX_CTRL_ONE, 32'h1);
        cfg(2'h1, 11'h000, 11'h002, 11'h004, 11'h001, 11'h003);
        count_active(8, 2, 2);
        rchk(`DPW_IDX_RUN_CTRL, 32'h1);
        report_and_stop;
    end
endmodule
